// *** rtl/isrg_pkg.sv ***
package isrg_pkg;

    // ------------------------------------------------------------
    // Group selection and register selection codes
    // ------------------------------------------------------------
    localparam logic [0:0] GRP_HW_TWO = 1'h0;
    localparam logic [0:0] GRP_MEAS = 1'h1;

    localparam logic [2:0] REG_CONDITION = 3'h0;
    localparam logic [2:0] REG_RISE_FILTER = 3'h1;
    localparam logic [2:0] REG_FALL_FILTER = 3'h2;
    localparam logic [2:0] REG_EVENT_LATCH = 3'h3;
    localparam logic [2:0] REG_ENABLE_MASK = 3'h4;

    // ------------------------------------------------------------
    // Bit positions and reset values
    // ------------------------------------------------------------
    localparam int RESERVED_BIT = 15;
    localparam int STB_HW_TWO_BIT = 1;
    localparam int STB_MEAS_BIT = 7;
    localparam int STB_WIDTH = 8;
    localparam logic [15:0] HW_TWO_IMPL_MASK = 16'h5fff;
    localparam logic [15:0] MEAS_IMPL_MASK = 16'h0007;
    localparam logic [15:0] RISE_RESET = 16'h7fff;
    localparam logic [15:0] FALL_RESET = 16'h0000;
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] EVENT_RESET = 16'h0000;

    typedef struct packed {
        logic valid;
        logic write;
        logic [0:0] group;
        logic [2:0] sel;
        logic [15:0] wdata;
    } isrg_cmd_t;

    typedef struct packed {
        logic [15:0] cond;
        logic [15:0] rise;
        logic [15:0] fall;
        logic [15:0] event_latch;
        logic [15:0] enable;
    } isrg_group_t;

    typedef struct packed {
        isrg_group_t [1:0] grp;
        logic [15:0] rdata;
        logic rvalid;
    } isrg_state_t;

endpackage

// *** rtl/isrg_status_groups.sv ***
`timescale 1ns/1ps

// Overview of operation
// - Event register clears on its own read and on clear-status.
// - Second hardware group summary drives status byte bit one.
// - Measurement group summary path ends at status byte bit seven.
// - Measurement summary reaches status byte only if enabled in operation group.
// - Bit 15 reads zero in both groups.
// - Hw bit 14 pending DSP interval, bit 12 reference unlock, 13 unused.
// - Hw bit 11 held while ACP channel and resolution bandwidth conflict.
// - Hw bit 10 held while ACP bandwidth or offset too wide.
// - Hw bit 9 held while audio source one outside notch range.
// - Hw bit 8 held while audio source two voltage request too large.
// - Hw bit 7 held while FM deviation too large for RF frequency.
// - Hw bit 6 held while simultaneous AM and FM requested.
// - Hw bit 5 held on audio input autoranging error.
// - Hw bit 4 held on RF input level autoranging error.
// - Hw bit 3 held on RF input frequency autotuning error.
// - Hw bit 2 held while generator minus analyzer differs from offset.
// - Hw bit 1 held while generator amplitude too high for port.
// - Hw bit 0 held while analyzer reference level wrong for port.
// - Meas bits 2,1,0 gated power, open-loop, frame error tests running.
// - Rise and fall filters readable and writable per group.
// - Enable masks readable and writable, persisting until rewritten.
// - Condition query returns live bits and changes nothing.
module isrg_status_groups (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [15:0] i_hw_two_cond,
    input wire logic [2:0] i_measurement_running_condition,
    input wire logic i_clear_status,
    input wire logic i_meas_summary_enabled,
    input wire isrg_pkg::isrg_cmd_t i_cmd,
    output logic [15:0] o_rdata,
    output logic o_rvalid,
    output logic [isrg_pkg::STB_WIDTH-1:0] o_status_byte_bits,
    output logic o_meas_group_summary
);

    // ------------------------------------------------------------
    // Condition synchronisers
    // ------------------------------------------------------------
    // Conditions come from analog hardware, outside the clock domain
    logic [15:0] hw_meta_q;
    logic [15:0] hw_sync_q;
    logic [2:0] meas_meta_q;
    logic [2:0] meas_sync_q;
    logic [15:0] cond_live [2];

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            hw_meta_q <= 16'h0000;
            hw_sync_q <= 16'h0000;
            meas_meta_q <= 3'h0;
            meas_sync_q <= 3'h0;
        end else begin
            hw_meta_q <= i_hw_two_cond;
            hw_sync_q <= hw_meta_q;
            meas_meta_q <= i_measurement_running_condition;
            meas_sync_q <= meas_meta_q;
        end
    end

    // Hw bits 11 to 6 straight through
    // Hw bits 5 to 0 straight through
    assign cond_live[isrg_pkg::GRP_HW_TWO] = hw_sync_q & isrg_pkg::HW_TWO_IMPL_MASK;
    assign cond_live[isrg_pkg::GRP_MEAS] = {13'h0000, meas_sync_q} & isrg_pkg::MEAS_IMPL_MASK;

    // ------------------------------------------------------------
    // Group state
    // ------------------------------------------------------------
    isrg_pkg::isrg_state_t st_q;
    isrg_pkg::isrg_state_t st_d;
    logic [1:0] summary;

    always_comb begin
        logic [15:0] rise_edge;
        logic [15:0] fall_edge;
        logic [15:0] hits;
        logic hit_sel;
        rise_edge = 16'h0000;
        fall_edge = 16'h0000;
        hits = 16'h0000;
        hit_sel = 1'b0;
        st_d = st_q;
        st_d.rvalid = 1'b0;
        for (int g = 0; g < 2; g++) begin
            hit_sel = i_cmd.valid && (i_cmd.group == 1'(g));
            st_d.grp[g].cond = cond_live[g];
            rise_edge = cond_live[g] & ~st_q.grp[g].cond;
            fall_edge = ~cond_live[g] & st_q.grp[g].cond;
            hits = (rise_edge & st_q.grp[g].rise) | (fall_edge & st_q.grp[g].fall);
            if (i_clear_status || (hit_sel && !i_cmd.write
                    && i_cmd.sel == isrg_pkg::REG_EVENT_LATCH)) begin
                st_d.grp[g].event_latch = isrg_pkg::EVENT_RESET;
            end
            // New events win over a same-cycle clear
            st_d.grp[g].event_latch = (st_d.grp[g].event_latch | hits)
                & ~(16'h0001 << isrg_pkg::RESERVED_BIT);
            if (hit_sel && i_cmd.write) begin
                case (i_cmd.sel)
                    isrg_pkg::REG_RISE_FILTER: begin
                        st_d.grp[g].rise = i_cmd.wdata;
                    end
                    isrg_pkg::REG_FALL_FILTER: begin
                        st_d.grp[g].fall = i_cmd.wdata;
                    end
                    isrg_pkg::REG_ENABLE_MASK: begin
                        st_d.grp[g].enable = i_cmd.wdata;
                    end
                    default: begin
                    end
                endcase
            end
            if (hit_sel && !i_cmd.write) begin
                st_d.rvalid = 1'b1;
                case (i_cmd.sel)
                    isrg_pkg::REG_CONDITION: st_d.rdata = cond_live[g];
                    isrg_pkg::REG_RISE_FILTER: st_d.rdata = st_q.grp[g].rise;
                    isrg_pkg::REG_FALL_FILTER: st_d.rdata = st_q.grp[g].fall;
                    isrg_pkg::REG_EVENT_LATCH: st_d.rdata = st_q.grp[g].event_latch;
                    isrg_pkg::REG_ENABLE_MASK: st_d.rdata = st_q.grp[g].enable;
                    default: st_d.rdata = 16'h0000;
                endcase
                st_d.rdata[isrg_pkg::RESERVED_BIT] = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int g = 0; g < 2; g++) begin
                st_q.grp[g].cond <= 16'h0000;
                st_q.grp[g].rise <= isrg_pkg::RISE_RESET;
                st_q.grp[g].fall <= isrg_pkg::FALL_RESET;
                st_q.grp[g].event_latch <= isrg_pkg::EVENT_RESET;
                st_q.grp[g].enable <= isrg_pkg::ENABLE_RESET;
            end
            st_q.rdata <= 16'h0000;
            st_q.rvalid <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Summary routing
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sum
            assign summary[gi] = |(st_q.grp[gi].event_latch & st_q.grp[gi].enable);
        end
    endgenerate

    always_comb begin
        o_status_byte_bits = '0;
        o_status_byte_bits[isrg_pkg::STB_HW_TWO_BIT] = summary[isrg_pkg::GRP_HW_TWO];
        // Through operation group enable to bit seven
        o_status_byte_bits[isrg_pkg::STB_MEAS_BIT] =
            summary[isrg_pkg::GRP_MEAS] & i_meas_summary_enabled;
    end

    assign o_meas_group_summary = summary[isrg_pkg::GRP_MEAS];
    assign o_rdata = st_q.rdata;
    assign o_rvalid = st_q.rvalid;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_EVENT_CLEARED: assert property (@(posedge i_clk) disable iff (i_rst)
        i_clear_status |=> ((st_q.grp[0].event_latch
            & ~$past(cond_live[0] ^ st_q.grp[0].cond)) == 16'h0000))
        else $error("event latch not cleared");
    AST_HW_STB_BIT: assert property (@(posedge i_clk) disable iff (i_rst)
        o_status_byte_bits[1] == |(st_q.grp[0].event_latch & st_q.grp[0].enable))
        else $error("hw summary not on bit one");
    AST_MEAS_STB_BIT: assert property (@(posedge i_clk) disable iff (i_rst)
        o_status_byte_bits[7] |-> o_meas_group_summary)
        else $error("bit seven without meas summary");
    AST_MEAS_GATED: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_meas_summary_enabled |-> !o_status_byte_bits[7])
        else $error("meas summary leaked");
    AST_BIT15_ZERO: assert property (@(posedge i_clk) disable iff (i_rst)
        o_rvalid |-> !o_rdata[15])
        else $error("bit 15 read nonzero");
    AST_COND_LATENCY: assert property (@(posedge i_clk) disable iff (i_rst)
        ##3 (cond_live[0][11] == $past(i_hw_two_cond[11], 2)))
        else $error("condition bit 11 not tracking");
    AST_COND_READ: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_cmd.valid && !i_cmd.write && i_cmd.sel == 3'h0 && i_cmd.group == 1'b0)
        |=> o_rvalid && o_rdata == $past(cond_live[0]))
        else $error("condition read wrong");
    AST_RISE_LATCH: assert property (@(posedge i_clk) disable iff (i_rst)
        (cond_live[1][0] && !st_q.grp[1].cond[0] && st_q.grp[1].rise[0])
        |=> st_q.grp[1].event_latch[0])
        else $error("rising event lost");
    AST_ENABLE_WRITE: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_cmd.valid && i_cmd.write && i_cmd.sel == 3'h4 && i_cmd.group == 1'b0)
        |=> st_q.grp[0].enable == $past(i_cmd.wdata))
        else $error("enable write lost");

    // ------------------------------------------------------------
    // Checks on event clearing
    // ------------------------------------------------------------
    // Only bits with an edge in the clearing cycle may survive
    AST_MEAS_CLEARED: assert property (@(posedge i_clk) disable iff (i_rst)
        i_clear_status |=> ((st_q.grp[1].event_latch
            & ~$past(cond_live[1] ^ st_q.grp[1].cond)) == 16'h0000))
        else $error("meas event latch not cleared");
    AST_HW_READ_CLEAR: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_cmd.valid && !i_cmd.write && i_cmd.group == 1'b0 && i_cmd.sel == 3'h3)
        |=> ((st_q.grp[0].event_latch
            & ~$past(cond_live[0] ^ st_q.grp[0].cond)) == 16'h0000))
        else $error("hw event latch kept after read");
    AST_MEAS_READ_CLEAR: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_cmd.valid && !i_cmd.write && i_cmd.group == 1'b1 && i_cmd.sel == 3'h3)
        |=> ((st_q.grp[1].event_latch
            & ~$past(cond_live[1] ^ st_q.grp[1].cond)) == 16'h0000))
        else $error("meas event latch kept after read");
    AST_EVENT_KEEP: assert property (@(posedge i_clk) disable iff (i_rst)
        (!i_clear_status && !(i_cmd.valid && !i_cmd.write && i_cmd.sel == 3'h3))
        |=> ((st_q.grp[0].event_latch & $past(st_q.grp[0].event_latch))
            == $past(st_q.grp[0].event_latch)))
        else $error("hw event lost without clear");
    AST_MEAS_EVENT_KEEP: assert property (@(posedge i_clk) disable iff (i_rst)
        (!i_clear_status && !(i_cmd.valid && !i_cmd.write && i_cmd.sel == 3'h3))
        |=> ((st_q.grp[1].event_latch & $past(st_q.grp[1].event_latch))
            == $past(st_q.grp[1].event_latch)))
        else $error("meas event lost without clear");

    // ------------------------------------------------------------
    // Checks on status byte routing
    // ------------------------------------------------------------
    AST_STB_UNUSED_ZERO: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_status_byte_bits & 8'h7d) == 8'h00)
        else $error("unused status byte bit set");
    AST_MEAS_STB_SET: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_meas_group_summary && i_meas_summary_enabled) |-> o_status_byte_bits[7])
        else $error("enabled meas summary missing on bit seven");
    AST_MEAS_SUMMARY: assert property (@(posedge i_clk) disable iff (i_rst)
        o_meas_group_summary == ((st_q.grp[1].event_latch & st_q.grp[1].enable) != 16'h0000))
        else $error("meas summary wrong");

    // ------------------------------------------------------------
    // Checks on condition bits
    // ------------------------------------------------------------
    AST_HW_RESERVED_LOW: assert property (@(posedge i_clk) disable iff (i_rst)
        !cond_live[0][15] && !st_q.grp[0].event_latch[15])
        else $error("hw bit 15 set");
    AST_MEAS_RESERVED_LOW: assert property (@(posedge i_clk) disable iff (i_rst)
        !cond_live[1][15] && !st_q.grp[1].event_latch[15])
        else $error("meas bit 15 set");
    AST_HW_BIT13_UNUSED: assert property (@(posedge i_clk) disable iff (i_rst)
        !cond_live[0][13] && !st_q.grp[0].event_latch[13])
        else $error("hw bit 13 set");
    AST_COND_BIT14: assert property (@(posedge i_clk) disable iff (i_rst)
        ##3 (cond_live[0][14] == $past(i_hw_two_cond[14], 2)))
        else $error("condition bit 14 not tracking");
    AST_COND_BIT12: assert property (@(posedge i_clk) disable iff (i_rst)
        ##3 (cond_live[0][12] == $past(i_hw_two_cond[12], 2)))
        else $error("condition bit 12 not tracking");
    AST_COND_BIT10: assert property (@(posedge i_clk) disable iff (i_rst)
        ##3 (cond_live[0][10] == $past(i_hw_two_cond[10], 2)))
        else $error("condition bit 10 not tracking");
    AST_COND_BIT9: assert property (@(posedge i_clk) disable iff (i_rst)
        ##3 (cond_live[0][9] == $past(i_hw_two_cond[9], 2)))
        else $error("condition bit 9 not tracking");
    AST_COND_BIT8: assert property (@(posedge i_clk) disable iff (i_rst)
        ##3 (cond_live[0][8] == $past(i_hw_two_cond[8], 2)))
        else $error("condition bit 8 not tracking");
    AST_COND_BIT7: assert property (@(posedge i_clk) disable iff (i_rst)
        ##3 (cond_live[0][7] == $past(i_hw_two_cond[7], 2)))
        else $error("condition bit 7 not tracking");
    AST_COND_BIT6: assert property (@(posedge i_clk) disable iff (i_rst)
        ##3 (cond_live[0][6] == $past(i_hw_two_cond[6], 2)))
        else $error("condition bit 6 not tracking");
    AST_COND_BIT5: assert property (@(posedge i_clk) disable iff (i_rst)
        ##3 (cond_live[0][5] == $past(i_hw_two_cond[5], 2)))
        else $error("condition bit 5 not tracking");
    AST_COND_BIT4: assert property (@(posedge i_clk) disable iff (i_rst)
        ##3 (cond_live[0][4] == $past(i_hw_two_cond[4], 2)))
        else $error("condition bit 4 not tracking");
    AST_COND_BIT3: assert property (@(posedge i_clk) disable iff (i_rst)
        ##3 (cond_live[0][3] == $past(i_hw_two_cond[3], 2)))
        else $error("condition bit 3 not tracking");
    AST_COND_BIT2: assert property (@(posedge i_clk) disable iff (i_rst)
        ##3 (cond_live[0][2] == $past(i_hw_two_cond[2], 2)))
        else $error("condition bit 2 not tracking");
    AST_COND_BIT1: assert property (@(posedge i_clk) disable iff (i_rst)
        ##3 (cond_live[0][1] == $past(i_hw_two_cond[1], 2)))
        else $error("condition bit 1 not tracking");
    AST_COND_BIT0: assert property (@(posedge i_clk) disable iff (i_rst)
        ##3 (cond_live[0][0] == $past(i_hw_two_cond[0], 2)))
        else $error("condition bit 0 not tracking");
    AST_MEASUREMENT_RUNNING_CONDITION_TRACK: assert property (@(posedge i_clk) disable iff (i_rst)
        ##3 (cond_live[1][2:0] == $past(i_measurement_running_condition, 2)))
        else $error("meas condition not tracking");
    AST_MEAS_UNUSED: assert property (@(posedge i_clk) disable iff (i_rst)
        cond_live[1][15:3] == 13'h0000)
        else $error("unused meas condition set");

    // ------------------------------------------------------------
    // Checks on edges and register access
    // ------------------------------------------------------------
    AST_FALL_LATCH: assert property (@(posedge i_clk) disable iff (i_rst)
        (!cond_live[0][14] && st_q.grp[0].cond[14] && st_q.grp[0].fall[14])
        |=> st_q.grp[0].event_latch[14])
        else $error("falling event lost");
    AST_HW_RISE_LATCH: assert property (@(posedge i_clk) disable iff (i_rst)
        (cond_live[0][0] && !st_q.grp[0].cond[0] && st_q.grp[0].rise[0])
        |=> st_q.grp[0].event_latch[0])
        else $error("hw rising event lost");
    AST_MEAS_FALL_LATCH: assert property (@(posedge i_clk) disable iff (i_rst)
        (!cond_live[1][2] && st_q.grp[1].cond[2] && st_q.grp[1].fall[2])
        |=> st_q.grp[1].event_latch[2])
        else $error("meas falling event lost");
    AST_NO_SPURIOUS_EVENT: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_q.grp[0].event_latch & ~$past(st_q.grp[0].event_latch)
            & ~$past(cond_live[0] ^ st_q.grp[0].cond)) == 16'h0000)
        else $error("event bit set without edge");
    AST_HW_RISE_WRITE: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_cmd.valid && i_cmd.write && i_cmd.sel == 3'h1 && i_cmd.group == 1'b0)
        |=> st_q.grp[0].rise == $past(i_cmd.wdata))
        else $error("hw rise filter write lost");
    AST_MEAS_FALL_WRITE: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_cmd.valid && i_cmd.write && i_cmd.sel == 3'h2 && i_cmd.group == 1'b1)
        |=> st_q.grp[1].fall == $past(i_cmd.wdata))
        else $error("meas fall filter write lost");
    AST_REFUSED_WRITE: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_cmd.valid && i_cmd.write && i_cmd.sel > 3'h4)
        |=> $stable(st_q.grp[0].rise) && $stable(st_q.grp[0].fall)
            && $stable(st_q.grp[0].enable))
        else $error("refused write changed a setting");
    AST_ENABLE_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
        !(i_cmd.valid && i_cmd.write && i_cmd.group == 1'b0 && i_cmd.sel == 3'h4)
        |=> $stable(st_q.grp[0].enable))
        else $error("enable changed without write");
    AST_READ_ANSWER: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_cmd.valid && !i_cmd.write) |=> o_rvalid)
        else $error("read not answered");
    AST_NO_STRAY_ANSWER: assert property (@(posedge i_clk) disable iff (i_rst)
        !(i_cmd.valid && !i_cmd.write) |=> !o_rvalid)
        else $error("answer without read");
    AST_RDATA_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
        !(i_cmd.valid && !i_cmd.write) |=> $stable(o_rdata))
        else $error("read data changed without read");
    AST_READ_NO_SIDE: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_cmd.valid && !i_cmd.write)
        |=> $stable(st_q.grp[0].rise) && $stable(st_q.grp[0].fall)
            && $stable(st_q.grp[0].enable) && $stable(st_q.grp[1].rise))
        else $error("read changed a setting");
    AST_COND_READ_KEEP: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_cmd.valid && !i_cmd.write && i_cmd.sel == 3'h0 && !i_clear_status)
        |=> ((st_q.grp[0].event_latch & $past(st_q.grp[0].event_latch))
            == $past(st_q.grp[0].event_latch)))
        else $error("condition read cleared events");

endmodule

// *** test/isrg_host_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Remote controller issuing status commands
// ------------------------------------------------------------
module isrg_host_model (
    input wire logic i_clk,
    input wire logic [15:0] i_rdata,
    input wire logic i_rvalid,
    output isrg_pkg::isrg_cmd_t o_cmd
);
    initial o_cmd = '0;
    task automatic wr(input logic [0:0] g, input logic [2:0] s, input logic [15:0] d);
        @(negedge i_clk);
        o_cmd <= '{1'b1, 1'b1, g, s, d};
        @(negedge i_clk);
        o_cmd.valid <= 1'b0;
        // Stale data inverted once released
        o_cmd.wdata <= ~d;
    endtask
    task automatic rd(input logic [0:0] g, input logic [2:0] s, output logic [15:0] d,
                      output bit ok);
        @(negedge i_clk);
        o_cmd <= '{1'b1, 1'b0, g, s, 16'h0000};
        @(negedge i_clk);
        o_cmd.valid <= 1'b0;
        ok = 1'b0;
        d = 16'hxxxx;
        for (int i = 0; i < 4 && !ok; i++) begin
            if (i_rvalid === 1'b1) begin
                ok = 1'b1;
                d = i_rdata;
            end else begin
                @(negedge i_clk);
            end
        end
    endtask
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [15:0] hw_cond = 16'h0000;
    logic [2:0] measurement_running_condition = 3'h0;
    logic clr = 1'b0;
    logic meas_en = 1'b0;
    isrg_pkg::isrg_cmd_t cmd;
    logic [15:0] rdata;
    logic rvalid;
    logic [7:0] stb;
    logic meas_sum;
    int err_count = 0;
    int comparisons = 0;
    always #25 i_clk = ~i_clk;
    isrg_host_model isrg_host_model_i (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid),
        .o_cmd(cmd));
    isrg_status_groups isrg_status_groups_i (.i_clk(i_clk), .i_rst(i_rst),
        .i_hw_two_cond(hw_cond), .i_measurement_running_condition(measurement_running_condition), .i_clear_status(clr),
        .i_meas_summary_enabled(meas_en), .i_cmd(cmd), .o_rdata(rdata), .o_rvalid(rvalid),
        .o_status_byte_bits(stb), .o_meas_group_summary(meas_sum));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] ex);
        comparisons++;
        if (seen !== ex) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, ex, seen);
        end
    endtask
    task automatic rchk(input string nm, input logic [0:0] g, input logic [2:0] s,
                        input logic [15:0] ex);
        logic [15:0] d;
        bit ok;
        isrg_host_model_i.rd(g, s, d, ok);
        if (!ok) begin
            err_count++;
            $display("[ERR] %s expected answer seen none", nm);
            complete_run();
        end else begin
            chk(nm, d, ex);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [15:0] ev;
        idle(12);
        i_rst = 1'b0;
        rchk("hw rise", 0, 1, isrg_pkg::RISE_RESET);
        rchk("hw fall", 0, 2, 16'h0000);
        rchk("hw enab", 0, 4, 16'h0000);
        rchk("meas rise", 1, 1, isrg_pkg::RISE_RESET);
        $display("test reset_values done");
        hw_cond = 16'hffff;
        measurement_running_condition = 3'h7;
        idle(4);
        rchk("hw cond", 0, 0, 16'h5fff);
        rchk("hw cond again", 0, 0, 16'h5fff);
        rchk("measurement_running_condition", 1, 0, 16'h0007);
        rchk("hw event", 0, 3, 16'h5fff);
        rchk("hw event reread", 0, 3, 16'h0000);
        for (int b = 0; b < 16; b++) begin
            hw_cond = 16'h0000;
            idle(4);
            rchk("hw fall unfiltered", 0, 3, 16'h0000);
            hw_cond = 16'h0001 << b;
            ev = hw_cond & 16'h5fff;
            idle(4);
            rchk("hw cond bit", 0, 0, ev);
            rchk("hw event bit", 0, 3, ev);
        end
        $display("test condition_bits done");
        hw_cond = 16'h4000;
        idle(4);
        isrg_host_model_i.wr(0, 1, 16'h0001);
        isrg_host_model_i.wr(0, 2, 16'h4000);
        isrg_host_model_i.wr(0, 4, 16'h8001);
        rchk("hw event", 0, 3, 16'h4000);
        rchk("hw rise wr", 0, 1, 16'h0001);
        rchk("hw fall wr", 0, 2, 16'h4000);
        rchk("hw enab wr", 0, 4, 16'h0001);
        hw_cond = 16'h0000;
        idle(4);
        chk("stb masked", {8'h00, stb}, 16'h0000);
        hw_cond = 16'h0001;
        idle(4);
        chk("stb hw", {8'h00, stb}, 16'h0002);
        clr = 1'b1;
        idle(1);
        clr = 1'b0;
        idle(1);
        chk("stb cleared", {8'h00, stb}, 16'h0000);
        rchk("hw event cls", 0, 3, 16'h0000);
        rchk("hw enab kept", 0, 4, 16'h0001);
        $display("test hw_summary done");
        isrg_host_model_i.wr(1, 4, 16'h0004);
        measurement_running_condition = 3'h0;
        idle(4);
        measurement_running_condition = 3'h4;
        idle(4);
        chk("meas sum", {15'h0000, meas_sum}, 16'h0001);
        chk("stb meas off", {8'h00, stb}, 16'h0000);
        meas_en = 1'b1;
        idle(1);
        chk("stb meas on", {8'h00, stb}, 16'h0080);
        rchk("meas event", 1, 3, 16'h0004);
        chk("stb meas read", {8'h00, stb}, 16'h0000);
        isrg_host_model_i.wr(1, 2, 16'h0004);
        measurement_running_condition = 3'h0;
        idle(4);
        rchk("meas fall event", 1, 3, 16'h0004);
        rchk("meas fall wr", 1, 2, 16'h0004);
        isrg_host_model_i.wr(0, 5, 16'h0000);
        rchk("hw rise kept", 0, 1, 16'h0001);
        rchk("bad sel", 0, 5, 16'h0000);
        $display("test meas_summary done");
        complete_run();
    end
endmodule
